// [verilog/aip_pkg.sv]
/*
 * Constants, types and helpers for the converter's two-wire result and
 * configuration port. Assumes a 100 MHz system clock.
 */
// Contract
// - Address then direction bit; 1 means read
// - Answer only own pin-selected address
// - Address during conversion gets NAK
// - Address after conversion gets ACK
// - Shift 16 result bits after falling SCL
// - Read ends after 16 bits and two ACK slots, or START/STOP
// - Result sent most significant bit first
// - Differential: offset binary, clamped both ends
// - Single-ended: straight binary, clamped both ends
// - Write carries four bits: enables, speed, sleep
// - First enable bit on first rise after ACK
// - Settings change only for enables 1,0
// - Single-ended speed: 60Hz plain, 30Hz calibrated
// - Differential always 60Hz with calibration
// - Sleep set: reference off after next conversion
// - Reference powers up on address acknowledge
// - Completed read starts a new conversion
// - Read address, ACK, STOP restarts conversion
// - Idle after conversion until acknowledged transfer
// - Result MSB presented on entering transfer
// - Reset clears settings, then converts at once
package aip_pkg;

    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned RATE_FAST_HZ = 60;
    localparam int unsigned RATE_SLOW_HZ = 30;
    localparam int unsigned CONV_FAST_CYC = CLK_HZ / RATE_FAST_HZ;
    localparam int unsigned CONV_SLOW_CYC = CLK_HZ / RATE_SLOW_HZ;
    localparam int unsigned CONV_CNT_W    = 22;

    localparam logic [6:0] ADDR_SEL_HIGH = 7'h14;
    localparam logic [6:0] ADDR_SEL_LOW  = 7'h54;

    localparam int unsigned RES_W       = 16;
    localparam logic [16:0] CODE_MID    = 17'h08000;
    localparam logic [16:0] CODE_MAX    = 17'h0FFFF;
    localparam logic [4:0] RD_SLOT_ACK1 = 5'h08;
    localparam logic [4:0] RD_SLOT_LAST = 5'h11;
    localparam logic [3:0] ADDR_BITS    = 4'h8;
    localparam logic [2:0] WR_BITS      = 3'h4;

    localparam logic [3:0] OFS_CFG    = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam int unsigned CFG_DIFF_BIT  = 0;
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_REF_BIT    = 1;
    localparam int unsigned ST_RATE_BIT   = 2;
    localparam int unsigned ST_SLEEP_BIT  = 3;
    localparam int unsigned ST_CALIB_BIT  = 4;
    localparam logic CFG_DIFF_RST = 1'b0;

    typedef struct packed {
        logic rate_select_bit;
        logic reference_sleep_bit;
    } aip_cfg_t;

    localparam aip_cfg_t SETTINGS_RST = '{rate_select_bit: 1'b0, reference_sleep_bit: 1'b0};

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_ADDR = 6'b000010,
        S_ACK  = 6'b000100,
        S_RD   = 6'b001000,
        S_WR   = 6'b010000,
        S_IGN  = 6'b100000
    } aip_state_t;

endpackage

// [verilog/aip_top.sv]
/*
 * Two-wire slave port of a 16-bit converter: address match, ACK/NAK by
 * conversion state, result shift-out, four-bit configuration write,
 * conversion timer and reference power control, plus a Wishbone status
 * slave. Assumes open-drain SCL/SDA resolved outside; SCL is sampled.
 */
`timescale 1ns/1ps
module aip_top #(
    parameter int unsigned CONV_FAST = aip_pkg::CONV_FAST_CYC,
    parameter int unsigned CONV_SLOW = aip_pkg::CONV_SLOW_CYC
) (
    input  wire logic        clk_i,        // System clock
    input  wire logic        rst_i,        // Synchronous reset, high
    input  wire logic        scl_i,        // Serial clock pin
    input  wire logic        sda_i,        // Serial data pin level
    output logic             sda_o,        // Serial data drive value
    output logic             sda_oe_o,     // Pull SDA low when high
    input  wire logic        addr_sel_i,   // Address select pin
    input  wire logic [17:0] sample_i,     // Signed modulator value, LSBs
    output logic             ref_power_o,  // Reference powered
    output logic             conv_busy_o,  // Conversion running
    output logic             calib_en_o,   // Background calibration on
    input  wire logic        wb_cyc_i,     // Wishbone cycle
    input  wire logic        wb_stb_i,     // Wishbone strobe
    input  wire logic        wb_we_i,      // Wishbone write
    input  wire logic [3:0]  wb_adr_i,     // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // Wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,     // Wishbone write data
    output logic [31:0]      wb_dat_o,     // Wishbone read data
    output logic             wb_ack_o      // Wishbone acknowledge
);

    // Clamp and encode the modulator value
    function automatic logic [15:0] fmt_code(input logic [17:0] s, input logic diff);
        logic signed [18:0] v;
        v = $signed({s[17], s});
        if (diff) begin
            v = v + $signed({2'b00, aip_pkg::CODE_MID});
        end
        if (v < 0) begin
            fmt_code = 16'h0000;
        end else if (v > $signed({2'b00, aip_pkg::CODE_MAX})) begin
            fmt_code = 16'hFFFF;
        end else begin
            fmt_code = v[15:0];
        end
    endfunction

    logic       scl_s1_r, scl_s2_r, scl_s3_r;
    logic       sda_s1_r, sda_s2_r, sda_s3_r;
    logic       asel_s1_r, asel_s2_r;
    logic       scl_rise, scl_fall, start_det, stop_det;

    aip_pkg::aip_state_t st_r;
    logic [7:0]  addr_sh_r;
    logic [3:0]  bit_cnt_r;
    logic [4:0]  rd_slot_r;
    logic [15:0] out_sh_r;
    logic        oe_r;
    logic        rw_r;
    logic [2:0]  wr_cnt_r;
    logic [3:0]  wr_word_r;
    logic [6:0]  own_addr;
    logic        addr_done, addr_hit, read_done, xfer_end, wr_apply;

    logic        busy_r;
    logic [aip_pkg::CONV_CNT_W-1:0] conv_cnt_r;
    logic [aip_pkg::CONV_CNT_W-1:0] conv_len;
    logic        conv_done;
    logic [15:0] result_r;
    logic        ref_on_r;
    aip_pkg::aip_cfg_t cfg_r;
    logic        diff_r;
    logic        wb_req;

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        scl_s1_r  <= scl_i;
        scl_s2_r  <= scl_s1_r;
        scl_s3_r  <= scl_s2_r;
        sda_s1_r  <= sda_i;
        sda_s2_r  <= sda_s1_r;
        sda_s3_r  <= sda_s2_r;
        asel_s1_r <= addr_sel_i;
        asel_s2_r <= asel_s1_r;
    end

    assign scl_rise  = scl_s2_r & ~scl_s3_r;
    assign scl_fall  = ~scl_s2_r & scl_s3_r;
    assign start_det = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
    assign stop_det  = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;

    // Pin high selects the low address
    assign own_addr  = asel_s2_r ? aip_pkg::ADDR_SEL_HIGH : aip_pkg::ADDR_SEL_LOW;
    assign addr_done = (st_r == aip_pkg::S_ADDR) && scl_fall && (bit_cnt_r == aip_pkg::ADDR_BITS);
    assign addr_hit  = addr_done && (addr_sh_r[7:1] == own_addr);
    assign read_done = (st_r == aip_pkg::S_RD) && scl_fall
                       && (rd_slot_r == aip_pkg::RD_SLOT_LAST);
    // Any end of an acknowledged transfer
    assign xfer_end  = read_done
                       || ((stop_det || start_det)
                           && (st_r == aip_pkg::S_RD || st_r == aip_pkg::S_WR
                               || st_r == aip_pkg::S_ACK));
    // Three bits in so far: enables in [2:1], rate in [0]; sleep is on the pin
    assign wr_apply  = (st_r == aip_pkg::S_WR) && scl_rise
                       && (wr_cnt_r == aip_pkg::WR_BITS - 3'h1)
                       && wr_word_r[2] && !wr_word_r[1];

    // Transfer state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= aip_pkg::S_IDLE;
        end else if (start_det) begin
            st_r <= aip_pkg::S_ADDR;
        end else if (stop_det) begin
            st_r <= aip_pkg::S_IDLE;
        end else begin
            case (st_r)
                aip_pkg::S_IDLE: st_r <= aip_pkg::S_IDLE;
                aip_pkg::S_ADDR: begin
                    if (addr_done) begin
                        st_r <= (addr_hit && !busy_r) ? aip_pkg::S_ACK : aip_pkg::S_IGN;
                    end
                end
                aip_pkg::S_ACK: begin
                    if (scl_fall) begin
                        st_r <= rw_r ? aip_pkg::S_RD : aip_pkg::S_WR;
                    end
                end
                aip_pkg::S_RD: begin
                    if (read_done) begin
                        st_r <= aip_pkg::S_IGN;
                    end
                end
                aip_pkg::S_WR:  st_r <= aip_pkg::S_WR;
                aip_pkg::S_IGN: st_r <= aip_pkg::S_IGN;
                default:        st_r <= aip_pkg::S_IDLE;
            endcase
        end
    end

    // Address and direction capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_sh_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            rw_r      <= 1'b0;
        end else if (start_det) begin
            addr_sh_r <= 8'h00;
            bit_cnt_r <= 4'h0;
        end else if (st_r == aip_pkg::S_ADDR && scl_rise && bit_cnt_r != aip_pkg::ADDR_BITS) begin
            addr_sh_r <= {addr_sh_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (addr_done) begin
            rw_r <= addr_sh_r[0];
        end
    end

    // Result shift-out and SDA drive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_r      <= 1'b0;
            out_sh_r  <= 16'h0000;
            rd_slot_r <= 5'h00;
        end else if (start_det || stop_det) begin
            oe_r <= 1'b0;
        end else if (addr_done) begin
            oe_r <= addr_hit && !busy_r;
        end else if (st_r == aip_pkg::S_ACK && scl_fall) begin
            out_sh_r  <= result_r;
            rd_slot_r <= 5'h00;
            oe_r      <= rw_r && !result_r[15];
        end else if (st_r == aip_pkg::S_RD && scl_fall) begin
            rd_slot_r <= rd_slot_r + 5'h01;
            if (rd_slot_r + 5'h01 == aip_pkg::RD_SLOT_ACK1
                || rd_slot_r == aip_pkg::RD_SLOT_LAST - 5'h01) begin
                oe_r <= 1'b0;
            end else if (rd_slot_r == aip_pkg::RD_SLOT_LAST) begin
                oe_r <= 1'b0;
            end else begin
                out_sh_r <= {out_sh_r[14:0], 1'b0};
                oe_r     <= !out_sh_r[14];
            end
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_r;

    // Configuration word input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_cnt_r  <= 3'h0;
            wr_word_r <= 4'h0;
        end else if (st_r == aip_pkg::S_ACK) begin
            wr_cnt_r <= 3'h0;
        end else if (st_r == aip_pkg::S_WR && scl_rise && wr_cnt_r != aip_pkg::WR_BITS) begin
            wr_word_r <= {wr_word_r[2:0], sda_s2_r};
            wr_cnt_r  <= wr_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= aip_pkg::SETTINGS_RST;
        end else if (wr_apply) begin
            cfg_r.rate_select_bit     <= wr_word_r[0];
            cfg_r.reference_sleep_bit <= sda_s2_r;
        end
    end

    // Conversion timer
    assign conv_len  = (cfg_r.rate_select_bit && !diff_r)
                       ? CONV_SLOW[aip_pkg::CONV_CNT_W-1:0]
                       : CONV_FAST[aip_pkg::CONV_CNT_W-1:0];
    assign conv_done = busy_r && (conv_cnt_r >= conv_len - 1'b1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r     <= 1'b1;
            conv_cnt_r <= '0;
        end else if (xfer_end) begin
            busy_r     <= 1'b1;
            conv_cnt_r <= '0;
        end else if (conv_done) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            conv_cnt_r <= conv_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r <= 16'h0000;
        end else if (conv_done) begin
            result_r <= fmt_code(sample_i, diff_r);
        end
    end

    // Reference power
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_on_r <= 1'b1;
        end else if (addr_hit && !busy_r) begin
            ref_on_r <= 1'b1;
        end else if (conv_done && cfg_r.reference_sleep_bit) begin
            ref_on_r <= 1'b0;
        end
    end

    assign ref_power_o = ref_on_r;
    assign conv_busy_o = busy_r;
    assign calib_en_o  = diff_r || cfg_r.rate_select_bit;

    // Wishbone slave
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diff_r <= aip_pkg::CFG_DIFF_RST;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == aip_pkg::OFS_CFG) begin
            diff_r <= wb_dat_i[aip_pkg::CFG_DIFF_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= 32'h00000000;
            case (wb_adr_i)
                aip_pkg::OFS_CFG: wb_dat_o[aip_pkg::CFG_DIFF_BIT] <= diff_r;
                aip_pkg::OFS_STATUS: begin
                    wb_dat_o[aip_pkg::ST_BUSY_BIT]  <= busy_r;
                    wb_dat_o[aip_pkg::ST_REF_BIT]   <= ref_on_r;
                    wb_dat_o[aip_pkg::ST_RATE_BIT]  <= cfg_r.rate_select_bit;
                    wb_dat_o[aip_pkg::ST_SLEEP_BIT] <= cfg_r.reference_sleep_bit;
                    wb_dat_o[aip_pkg::ST_CALIB_BIT] <= calib_en_o;
                end
                aip_pkg::OFS_RESULT: wb_dat_o[15:0] <= result_r;
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    a_nak_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        addr_done && busy_r |=> !sda_oe_o)
        else $error("Address acknowledged during conversion");

    a_ack_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        addr_hit && !busy_r && !start_det && !stop_det |=> sda_oe_o && st_r == aip_pkg::S_ACK)
        else $error("Finished conversion not acknowledged");

    a_ack_own_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r == aip_pkg::S_ACK |-> addr_sh_r[7:1] == own_addr)
        else $error("Acknowledged a foreign address");

    a_msb_first: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_r == aip_pkg::S_RD) |-> sda_oe_o == !result_r[15])
        else $error("Result MSB not presented on entry");

    a_read_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        read_done |=> busy_r && conv_cnt_r == '0 ##1 !sda_oe_o)
        else $error("Completed read did not restart conversion");

    a_stop_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_det && (st_r == aip_pkg::S_ACK || st_r == aip_pkg::S_RD)
        |=> busy_r && st_r == aip_pkg::S_IDLE)
        else $error("Stop after acknowledge did not restart");

    a_cfg_guard: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_apply |=> $stable(cfg_r))
        else $error("Settings changed without valid enables");

    a_sleep_ref: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_done && cfg_r.reference_sleep_bit && !addr_hit |=> !ref_power_o)
        else $error("Reference stayed on in sleep mode");

    a_wake_ref: assert property (@(posedge clk_i) disable iff (rst_i)
        addr_hit && !busy_r |=> ref_power_o [*2])
        else $error("Reference not powered on acknowledge");

    a_diff_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        diff_r |-> calib_en_o && conv_len == CONV_FAST[aip_pkg::CONV_CNT_W-1:0])
        else $error("Differential mode not at fast calibrated rate");

    a_reset_conv: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> busy_r && cfg_r == aip_pkg::SETTINGS_RST)
        else $error("Reset did not clear settings and start conversion");

    a_oe_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        sda_oe_o |-> st_r == aip_pkg::S_ACK || st_r == aip_pkg::S_RD)
        else $error("SDA pulled outside acknowledge or result phase");

endmodule

// [dv/aip_i2c_master.sv]
/*
 * Behavioural two-wire bus master that reads results and writes settings.
 * Assumes an external pull-up: SDA reads high when nobody pulls it low.
 */
`timescale 1ns/1ps
module aip_i2c_master (
    output logic      scl_o,      // Serial clock, idles high
    output logic      sda_pull_o, // High pulls SDA low
    input  wire logic sda_i       // Resolved SDA level
);
    localparam realtime QTR = 31.25;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // SDA falls while SCL high
    task automatic start_cond();
        sda_pull_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_pull_o = 1'b1;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    // Data changes only while SCL low; sampled mid-high
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull_o = !b;
        #QTR scl_o = 1'b1;
        #QTR r = sda_i;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    // SDA rises while SCL high
    task automatic stop_cond();
        sda_pull_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_pull_o = 1'b0;
        #(2*QTR);
    endtask
endmodule

// [dv/test_aip_top.sv]
/*
 * Self-checking bench for the converter's two-wire port and status slave.
 * Assumes shortened conversion counts and a master model on the bus.
 */
`timescale 1ns/1ps
module test_aip_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        addr_sel_i = 1'b1;
    logic [17:0] sample_i = 18'h0ABCD;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, sda_o, sda_oe_o, ref_power_o, conv_busy_o, calib_en_o;
    logic        scl_w, m_pull, ack;
    wire         sda_w = !((sda_oe_o && !sda_o) || m_pull);
    logic [31:0] st;
    logic [15:0] res;
    int          failures = 0, total_checks = 0, cycles = 0;

    always #5 clk_i = ~clk_i;

    aip_top #(.CONV_FAST(200), .CONV_SLOW(400)) aip_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
        .sample_i(sample_i), .ref_power_o(ref_power_o), .conv_busy_o(conv_busy_o),
        .calib_en_o(calib_en_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    aip_i2c_master aip_i2c_master_inst (
        .scl_o(scl_w), .sda_pull_o(m_pull), .sda_i(sda_w));

    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic single cycle: hold until ack seen at a rising edge
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic send_addr(input logic [6:0] a, input logic rw, output logic ak);
        logic r;
        aip_i2c_master_inst.start_cond();
        for (int i = 6; i >= 0; i--) aip_i2c_master_inst.xfer_bit(a[i], r);
        aip_i2c_master_inst.xfer_bit(rw, r);
        aip_i2c_master_inst.xfer_bit(1'b1, r);
        ak = !r;
    endtask

    // Master ACK after first byte, NAK after second
    task automatic read_result(output logic [15:0] d);
        logic r;
        for (int i = 15; i >= 0; i--) begin
            aip_i2c_master_inst.xfer_bit(1'b1, r);
            d[i] = r;
            if (i == 8 || i == 0) aip_i2c_master_inst.xfer_bit(i == 0, r);
        end
        aip_i2c_master_inst.stop_cond();
    endtask

    // Four setting bits, then their inverse as surplus bits
    task automatic write_cfg(input logic [6:0] a, input logic [3:0] bits);
        logic       r;
        logic [7:0] wd;
        wd = {bits, ~bits};
        send_addr(a, 1'b0, ack);
        check("write ack", 1, ack);
        check("ref on after ack", 1, ref_power_o);
        for (int i = 7; i >= 0; i--) aip_i2c_master_inst.xfer_bit(wd[i], r);
        aip_i2c_master_inst.stop_cond();
    endtask

    task automatic wait_idle();
        while (conv_busy_o !== 1'b0) @(posedge clk_i);
    endtask

    task automatic read_expect(input logic [6:0] a, input logic [15:0] exp);
        wait_idle();
        send_addr(a, 1'b1, ack);
        check("read ack", 1, ack);
        read_result(res);
        check("result", {16'h0, exp}, {16'h0, res});
        check("busy after read", 1, conv_busy_o);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        send_addr(7'h14, 1'b1, ack);
        check("nak while busy", 0, ack);
        aip_i2c_master_inst.stop_cond();
        wb_xfer(1'b0, 4'h4, 32'h0, st);
        check("status reset", 32'h3, st);
        // Drop the first conversion while the reference settles
        wait_idle();
        send_addr(7'h14, 1'b1, ack);
        check("abort ack", 1, ack);
        aip_i2c_master_inst.stop_cond();
        check("busy after abort", 1, conv_busy_o);
        read_expect(7'h14, 16'hABCD);
        @(posedge clk_i);
        sample_i <= 18'h1FFFF;
        wait_idle();
        send_addr(7'h54, 1'b1, ack);
        check("other address nak", 0, ack);
        aip_i2c_master_inst.stop_cond();
        @(posedge clk_i);
        addr_sel_i <= 1'b0;
        read_expect(7'h54, 16'hFFFF);
        @(posedge clk_i);
        sample_i <= 18'h3FFFF;
        read_expect(7'h54, 16'h0000);
        wait_idle();
        write_cfg(7'h54, 4'hB);
        wb_xfer(1'b0, 4'h4, 32'h0, st);
        check("status after write", 32'h1F, st);
        check("calib slow", 1, calib_en_o);
        repeat (300) @(posedge clk_i);
        check("slow still busy", 1, conv_busy_o);
        wait_idle();
        check("ref asleep", 0, ref_power_o);
        write_cfg(7'h54, 4'hC);
        wb_xfer(1'b0, 4'h4, 32'h0, st);
        check("bad enables ignored", 32'hC, st & 32'hC);
        wait_idle();
        wb_xfer(1'b1, 4'h0, 32'h1, st);
        wb_xfer(1'b0, 4'h0, 32'h0, st);
        check("cfg readback", 32'h1, st);
        write_cfg(7'h54, 4'h8);
        check("diff calib", 1, calib_en_o);
        read_expect(7'h54, 16'h7FFF);
        wb_xfer(1'b0, 4'hC, 32'h0, st);
        check("unmapped read", 32'h0, st);
        give_verdict();
    end
endmodule
